//--- amc_config_regs.sv
// Mode and clock configuration registers with APB slave, interrupt and ready pin
//
// Summary of operation
// - Mode bit 13 turns register-map check code on; resets off.
// - Mode bit 12 turns input check code checking on; resets off.
// - Mode bit 11 picks polynomial: 0 CCITT, 1 ANSI, both paths.
// - Mode bit 10 reads 1 after reset; writing 0 clears it.
// - Mode bits 9:8 pick word length; 00 16 bits, 01 24 bits, reset 01.
// - Codes 10 and 11 give 32-bit words, zero padded or sign extended.
// - Mode bit 4 enables the serial timeout; resets enabled.
// - Mode bit 1: idle ready pin driven high or floated.
// - Clock bits 8 to 11 enable lanes 0 to 3; reset enabled.
// - Clock bit 7 picks internal oscillator or external clock; resets external.
// - Clock bits 4:2 give ratio 128 doubled per step; reset 1024.
// - Clock bits 1:0: very-low, low, high resolution; reset 10.
// - Clock register sits at index 03h, resets to 0F8Eh.
// - Mode register sits at index 02h, resets to 0510h.
`timescale 1ns/10ps
module amc_config_regs
  import amc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [23:0] sampleIn,
  input  wire logic        sampleValid,
  input  wire logic        conversionAvail,
  output logic      [31:0] dataWord,
  output logic             dataWordValid,
  output logic             regCrcOn,
  output logic             rxCrcOn,
  output logic             crcPolySel,
  output logic             resetSeen,
  output logic      [1:0]  word_size_sel,
  output logic             timeoutOn,
  output logic             ready_pin_float_sel,
  output logic             lane0_on,
  output logic             lane1_on,
  output logic             lane2_on,
  output logic             lane3_on,
  output logic             clkSrcExt,
  output logic      [2:0]  oversample_ratio,
  output logic      [15:0] oversampleCount,
  output logic      [1:0]  power_level_sel,
  output amc_power_e       powerMode,
  output logic             data_ready_pin_out,
  output logic             data_ready_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and helpers

  amc_state_s  state;
  amc_state_s  next_state;
  logic [31:0] formattedWord;

  // Byte-lane merge; only the two low lanes carry register bits
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] oldValue,
    input logic [31:0] wdata,
    input logic [3:0]  strb,
    input logic [15:0] writeMask
  );
    logic [15:0] laneMask;
    laneMask = {{8{strb[1]}}, {8{strb[0]}}} & writeMask;
    return (oldValue & ~laneMask) | (wdata[15:0] & laneMask);
  endfunction : merge_lanes

  function automatic amc_power_e decode_power(input logic [1:0] code);
    amc_power_e mode;
    mode = PWR_HIGH_RES;
    unique case (code)
      2'h0: begin
        mode = PWR_VERY_LOW;
      end
      2'h1: begin
        mode = PWR_LOW;
      end
      2'h2, 2'h3: begin
        mode = PWR_HIGH_RES;
      end
    endcase
    return mode;
  endfunction : decode_power

  ////////////////////////////////////////////////////////////////////////////////
  // Word formatting

  amc_word_format u_word_format (
    .sample      (sampleIn),
    .wordSizeSel (state.mode[MODE_WSIZE_LSB +: 2]),
    .word        (formattedWord)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic                 accessPhase;
  logic                 commit;
  logic                 writeCommit;
  logic                 hitMode;
  logic                 hitClock;
  logic                 hitStatus;
  logic                 hitMask;
  logic                 mapped;
  logic [15:0]          mergedMode;
  logic [15:0]          mergedClock;
  logic [IRQ_WIDTH-1:0] irqSet;
  logic [IRQ_WIDTH-1:0] irqClear;
  logic [2:0]           osrCode;

  always_comb begin
    next_state  = state;
    irqSet      = '0;
    irqClear    = '0;

    hitClock    = (paddr == CLOCK_ADDR);
    hitMode     = (paddr == MODE_ADDR);
    hitStatus   = (paddr == IRQ_STATUS_ADDR);
    hitMask     = (paddr == IRQ_MASK_ADDR);
    mapped      = hitMode | hitClock | hitStatus | hitMask;

    // Ready comes one cycle into the access phase so all outputs stay registered
    accessPhase = psel & penable;
    commit      = accessPhase & state.pready;
    writeCommit = commit & pwrite & mapped;

    mergedMode  = merge_lanes(state.mode, pwdata, pstrb, MODE_WRITE_MASK);
    mergedMode[MODE_RESET_BIT] = state.mode[MODE_RESET_BIT] & mergedMode[MODE_RESET_BIT];

    mergedClock = merge_lanes(state.clock, pwdata, pstrb, CLOCK_WRITE_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // APB answer
    next_state.pready = accessPhase & ~state.pready;
    if (accessPhase && !state.pready) begin
      next_state.pslverr = ~mapped;
      next_state.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          hitMode: begin
            next_state.prdata = {16'h0000, state.mode};
          end
          hitClock: begin
            next_state.prdata = {16'h0000, state.clock & CLOCK_WRITE_MASK};
          end
          hitStatus: begin
            next_state.prdata = {{(32-IRQ_WIDTH){1'b0}}, state.irqStatus};
          end
          hitMask: begin
            next_state.prdata = {{(32-IRQ_WIDTH){1'b0}}, state.irqMask};
          end
          default: begin
            next_state.prdata = 32'h0000_0000;
          end
        endcase
      end
    end else if (commit) begin
      next_state.pslverr = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    if (writeCommit && hitMode) begin
      next_state.mode = mergedMode;
      irqSet[IRQ_MODE_WRITE] = 1'b1;
      if (state.mode[MODE_RESET_BIT] && !mergedMode[MODE_RESET_BIT]) begin
        irqSet[IRQ_RESET_CLEARED] = 1'b1;
      end
    end
    if (writeCommit && hitClock) begin
      next_state.clock = mergedClock;
      irqSet[IRQ_CLOCK_WRITE] = 1'b1;
    end
    if (writeCommit && hitMask) begin
      next_state.irqMask = pwdata[IRQ_WIDTH-1:0];
    end
    if (writeCommit && hitStatus) begin
      irqClear = pwdata[IRQ_WIDTH-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts; a new event beats a clear in the same cycle
    next_state.irqStatus = (state.irqStatus & ~irqClear) | irqSet;
    next_state.irq       = |(next_state.irqStatus & next_state.irqMask);

    ////////////////////////////////////////////////////////////////////////////
    // Decoded configuration is registered in the same cycle as the stored fields, with no lag
    osrCode = next_state.clock[CLOCK_OSR_LSB +: 3];
    next_state.oversampleCount = OSR_BASE_COUNT << osrCode;
    next_state.powerMode = decode_power(next_state.clock[CLOCK_PWR_LSB +: 2]);

    ////////////////////////////////////////////////////////////////////////////
    // Output words
    // formatted word captured
    next_state.dataWordValid = sampleValid;
    if (sampleValid) begin
      next_state.dataWord = formattedWord;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready pin is active low while data waits
    // idle high or floated
    if (conversionAvail) begin
      next_state.readyOut = 1'b0;
      next_state.readyOe  = 1'b1;
    end else begin
      next_state.readyOut = 1'b1;
      next_state.readyOe  = ~state.mode[MODE_FLOAT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flops

  assign prdata              = state.prdata;
  assign pready              = state.pready;
  assign pslverr             = state.pslverr;
  assign irq                 = state.irq;
  assign dataWord            = state.dataWord;
  assign dataWordValid       = state.dataWordValid;
  assign regCrcOn            = state.mode[MODE_REG_CRC_BIT];
  assign rxCrcOn             = state.mode[MODE_RX_CRC_BIT];
  assign crcPolySel          = state.mode[MODE_CRC_POLY_BIT];
  assign resetSeen           = state.mode[MODE_RESET_BIT];
  assign word_size_sel       = state.mode[MODE_WSIZE_LSB +: 2];
  assign timeoutOn           = state.mode[MODE_TIMEOUT_BIT];
  assign ready_pin_float_sel = state.mode[MODE_FLOAT_BIT];
  assign lane0_on            = state.clock[CLOCK_LANE_LSB];
  assign lane1_on            = state.clock[CLOCK_LANE_LSB + 1];
  assign lane2_on            = state.clock[CLOCK_LANE_LSB + 2];
  assign lane3_on            = state.clock[CLOCK_LANE_LSB + 3];
  assign clkSrcExt           = state.clock[CLOCK_SRC_BIT];
  assign oversample_ratio    = state.clock[CLOCK_OSR_LSB +: 3];
  assign oversampleCount     = state.oversampleCount;
  assign power_level_sel     = state.clock[CLOCK_PWR_LSB +: 2];
  assign powerMode           = state.powerMode;
  assign data_ready_pin_out  = state.readyOut;
  assign data_ready_pin_oe   = state.readyOe;

endmodule : amc_config_regs

//--- amc_config_regs_properties.sv
// Concurrent checks of the mode and clock register block
`timescale 1ns/10ps
module amc_config_regs_properties
  import amc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [23:0] sampleIn,
  input wire logic        sampleValid,
  input wire logic        conversionAvail,
  input wire logic [31:0] dataWord,
  input wire logic        regCrcOn,
  input wire logic        resetSeen,
  input wire logic [1:0]  word_size_sel,
  input wire logic        ready_pin_float_sel,
  input wire logic [2:0]  oversample_ratio,
  input wire logic [15:0] oversampleCount,
  input wire logic [1:0]  power_level_sel,
  input wire amc_power_e  powerMode,
  input wire logic        data_ready_pin_out,
  input wire logic        data_ready_pin_oe
);
  logic done;
  logic modeWr;
  assign done   = psel && penable && pready;
  assign modeWr = done && pwrite && paddr == MODE_ADDR && pstrb[1];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  a_crc_enable: assert property (modeWr |=> regCrcOn == $past(pwdata[13]))
    else $error("crc enable wrong");
  a_flag_clear: assert property (modeWr && !pwdata[10] |=> !resetSeen)
    else $error("reset flag not cleared");
  a_flag_hold: assert property (!resetSeen |=> !resetSeen)
    else $error("reset flag came back");
  a_word_pad: assert property (sampleValid && word_size_sel == WSIZE_32_PAD |=>
    dataWord == {$past(sampleIn), 8'h00}) else $error("padded word wrong");
  // Two quiet cycles so either pin latency passes
  a_pin_float: assert property ((!conversionAvail && ready_pin_float_sel) [*2] |=>
    !data_ready_pin_oe) else $error("idle pin not floated");
  a_pin_wait: assert property (conversionAvail [*2] |=>
    !data_ready_pin_out && data_ready_pin_oe) else $error("pin not low with data");
  a_osr_count: assert property (oversampleCount == OSR_BASE_COUNT << oversample_ratio)
    else $error("ratio count wrong");
  a_power_map: assert property (powerMode == (power_level_sel[1] ? PWR_HIGH_RES :
    amc_power_e'(power_level_sel))) else $error("power mode wrong");
  a_upper_zero: assert property (done && !pwrite && paddr == CLOCK_ADDR |->
    prdata[31:12] == 20'h0_0000) else $error("clock upper bits set");
endmodule : amc_config_regs_properties

bind amc_config_regs amc_config_regs_properties amc_config_regs_properties_inst (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .sampleIn(sampleIn), .sampleValid(sampleValid), .conversionAvail(conversionAvail),
  .dataWord(dataWord), .regCrcOn(regCrcOn), .resetSeen(resetSeen),
  .word_size_sel(word_size_sel), .ready_pin_float_sel(ready_pin_float_sel),
  .oversample_ratio(oversample_ratio), .oversampleCount(oversampleCount),
  .power_level_sel(power_level_sel), .powerMode(powerMode),
  .data_ready_pin_out(data_ready_pin_out), .data_ready_pin_oe(data_ready_pin_oe)
);

//--- amc_host.sv
// Host model: register bus master and sample source
`timescale 1ns/10ps
module amc_host
  import amc_pkg::*;
(
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic      [23:0] sampleIn,
  output logic             sampleValid,
  output logic             conversionAvail,
  input  wire logic        clk
);
  logic [31:0] rdata;
  logic        rerr;

  initial begin
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0000_0000;
    pstrb           = 4'h0;
    sampleIn        = 24'h00_0000;
    sampleValid     = 1'b0;
    conversionAvail = 1'b0;
  end

  ////////////////////////////////////////
  // Entered just after a rising edge; one idle edge follows each transfer
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines flip so nothing leans on stale values
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge clk);
  endtask : xfer

  task automatic cfg(input logic [15:0] m);
    xfer(1'b1, MODE_ADDR, {16'h0000, m & 16'h3F12}, 4'h3);
  endtask : cfg

  task automatic sample(input logic [23:0] s);
    sampleIn    <= s;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    sampleIn    <= ~s;
  endtask : sample
endmodule : amc_host

//--- amc_pkg.sv
// Constants, field layout and state type of the mode and clock configuration registers
package amc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses
  localparam logic [11:0] MODE_INDEX      = 12'h0002;
  localparam logic [11:0] CLOCK_INDEX     = 12'h0003;
  localparam logic [11:0] WORD_BYTES      = 12'h0004;
  localparam logic [11:0] MODE_ADDR       = 12'(MODE_INDEX * WORD_BYTES);
  localparam logic [11:0] CLOCK_ADDR      = 12'(CLOCK_INDEX * WORD_BYTES);
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h0010;
  localparam logic [11:0] IRQ_MASK_ADDR   = 12'h0014;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode register fields
  localparam int MODE_REG_CRC_BIT   = 13;
  localparam int MODE_RX_CRC_BIT    = 12;
  localparam int MODE_CRC_POLY_BIT  = 11;
  localparam int MODE_RESET_BIT     = 10;
  localparam int MODE_WSIZE_LSB     = 8;
  localparam int MODE_TIMEOUT_BIT   = 4;
  localparam int MODE_FLOAT_BIT     = 1;
  localparam logic [15:0] MODE_RESET_VALUE = 16'h0510;
  localparam logic [15:0] MODE_WRITE_MASK  = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock register fields
  localparam int CLOCK_LANE_LSB     = 8;
  localparam int CLOCK_SRC_BIT      = 7;
  localparam int CLOCK_OSR_LSB      = 2;
  localparam int CLOCK_PWR_LSB      = 0;
  localparam logic [15:0] CLOCK_RESET_VALUE = 16'h0F8E;
  localparam logic [15:0] CLOCK_WRITE_MASK  = 16'h0FFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Oversampling and word sizes
  localparam logic [15:0] OSR_BASE_COUNT  = 16'h0080;
  localparam logic [15:0] OSR_RESET_COUNT = 16'h0400;
  localparam logic [1:0]  WSIZE_16        = 2'h0;
  localparam logic [1:0]  WSIZE_24        = 2'h1;
  localparam logic [1:0]  WSIZE_32_PAD    = 2'h2;
  localparam logic [1:0]  WSIZE_32_SIGN   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  localparam int IRQ_WIDTH          = 3;
  localparam int IRQ_MODE_WRITE     = 0;
  localparam int IRQ_CLOCK_WRITE    = 1;
  localparam int IRQ_RESET_CLEARED  = 2;

  typedef enum logic [1:0] {
    PWR_VERY_LOW,
    PWR_LOW,
    PWR_HIGH_RES
  } amc_power_e;

  typedef struct packed {
    logic [15:0]          mode;
    logic [15:0]          clock;
    logic [IRQ_WIDTH-1:0] irqStatus;
    logic [IRQ_WIDTH-1:0] irqMask;
    logic                 irq;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          dataWord;
    logic                 dataWordValid;
    logic [15:0]          oversampleCount;
    amc_power_e           powerMode;
    logic                 readyOut;
    logic                 readyOe;
  } amc_state_s;

  localparam amc_state_s STATE_RESET = '{
    mode:            MODE_RESET_VALUE,
    clock:           CLOCK_RESET_VALUE,
    irqStatus:       '0,
    irqMask:         '0,
    irq:             1'b0,
    prdata:          32'h0000_0000,
    pready:          1'b0,
    pslverr:         1'b0,
    dataWord:        32'h0000_0000,
    dataWordValid:   1'b0,
    oversampleCount: OSR_RESET_COUNT,
    powerMode:       PWR_HIGH_RES,
    readyOut:        1'b1,
    readyOe:         1'b1
  };

endpackage : amc_pkg

//--- amc_word_format.sv
// Output word formatter for the selected data word length
`timescale 1ns/10ps
module amc_word_format
  import amc_pkg::*;
(
  input  wire logic [23:0] sample,
  input  wire logic [1:0]  wordSizeSel,
  output logic      [31:0] word
);

  always_comb begin
    word = 32'h0000_0000;
    unique case (wordSizeSel)
      // Short words keep the most significant part of the result
      WSIZE_16: begin
        word = {16'h0000, sample[23:8]};
      end
      WSIZE_24: begin
        word = {8'h00, sample};
      end
      WSIZE_32_PAD: begin
        word = {sample, 8'h00};
      end
      WSIZE_32_SIGN: begin
        word = {{8{sample[23]}}, sample};
      end
    endcase
  end

endmodule : amc_word_format

//--- tb.sv
// Self-checking testbench of the mode and clock register block
`timescale 1ns/10ps
module tb
  import amc_pkg::*;
;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, clkSrcExt;
  logic        sampleValid, conversionAvail, dataWordValid, regCrcOn, rxCrcOn, crcPolySel;
  logic        resetSeen, timeoutOn, ready_pin_float_sel, data_ready_pin_out, data_ready_pin_oe;
  logic        lane0_on, lane1_on, lane2_on, lane3_on;
  logic [1:0]  word_size_sel, power_level_sel;
  logic [2:0]  oversample_ratio;
  logic [3:0]  pstrb;
  logic [11:0] paddr;
  logic [15:0] oversampleCount, c;
  logic [23:0] sampleIn;
  logic [31:0] pwdata, prdata, dataWord;
  logic [31:0] expWord [4];
  amc_power_e  powerMode;
  int          errors;
  int          checksDone;

  amc_config_regs amc_config_regs_inst (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sampleIn(sampleIn), .sampleValid(sampleValid),
    .conversionAvail(conversionAvail), .dataWord(dataWord), .dataWordValid(dataWordValid),
    .regCrcOn(regCrcOn), .rxCrcOn(rxCrcOn), .crcPolySel(crcPolySel), .resetSeen(resetSeen),
    .word_size_sel(word_size_sel), .timeoutOn(timeoutOn),
    .ready_pin_float_sel(ready_pin_float_sel), .lane0_on(lane0_on), .lane1_on(lane1_on),
    .lane2_on(lane2_on), .lane3_on(lane3_on), .clkSrcExt(clkSrcExt),
    .oversample_ratio(oversample_ratio), .oversampleCount(oversampleCount),
    .power_level_sel(power_level_sel), .powerMode(powerMode),
    .data_ready_pin_out(data_ready_pin_out), .data_ready_pin_oe(data_ready_pin_oe)
  );
  amc_host        host (
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .conversionAvail(conversionAvail), .clk(clk)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000, 4'h0);
    cmp(host.rdata, exp);
  endtask : rd

  // Mode and clock outputs plus pin and interrupt {out, oe, irq}
  task automatic outs(input logic [15:0] m, input logic [15:0] k, input logic [2:0] p);
    @(negedge clk);
    cmp(32'({regCrcOn, rxCrcOn, crcPolySel, resetSeen, word_size_sel, timeoutOn,
      ready_pin_float_sel, data_ready_pin_out, data_ready_pin_oe, irq}), 32'({m[13:8], m[4], m[1], p}));
    cmp(32'({lane3_on, lane2_on, lane1_on, lane0_on, clkSrcExt, oversample_ratio,
      power_level_sel, powerMode}), 32'({k[11:7], k[4:0], k[1] ? 2'h2 : k[1:0]}));
    cmp(32'(oversampleCount), 32'h0000_0080 << k[4:2]);
    @(posedge clk);
  endtask : outs

  task automatic stop_test();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Tests take under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end

  initial begin
    errors     = 0;
    checksDone = 0;
    expWord    = '{32'h0000_8765, 32'h0087_6543, 32'h8765_4300, 32'hFF87_6543};
    reset_n    = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(MODE_ADDR, 32'h0000_0510);
    rd(CLOCK_ADDR, 32'h0000_0F8E);
    outs(16'h0510, 16'h0F8E, 3'b110);
    $display("reset test done");
    host.xfer(1'b1, MODE_ADDR, 32'h0000_0510, 4'h3);
    rd(MODE_ADDR, 32'h0000_0510);
    host.cfg(16'h3B12);
    rd(MODE_ADDR, 32'h0000_3B12);
    outs(16'h3B12, 16'h0F8E, 3'b100);
    host.xfer(1'b1, MODE_ADDR, 32'h0000_0000, 4'h1);
    outs(16'h3B00, 16'h0F8E, 3'b110);
    $display("mode test done");
    for (int i = 0; i < 8; i++) begin
      c = {(i == 7) ? 4'hF : 4'h0, 4'(i * 3), i[0], 2'b00, 3'(i), 2'(i)};
      host.xfer(1'b1, CLOCK_ADDR, {16'h0000, c}, 4'h3);
      c[15:12] = 4'h0;
      rd(CLOCK_ADDR, {16'h0000, c});
      outs(16'h3B00, c, 3'b110);
    end
    rd(IRQ_STATUS_ADDR, 32'h0000_0007);
    host.xfer(1'b1, IRQ_MASK_ADDR, 32'h0000_0004, 4'hF);
    outs(16'h3B00, c, 3'b111);
    host.xfer(1'b1, IRQ_STATUS_ADDR, 32'h0000_0004, 4'hF);
    rd(IRQ_STATUS_ADDR, 32'h0000_0003);
    host.xfer(1'b0, 12'h004, 32'h0000_0000, 4'h0);
    cmp({host.rdata[31:1], host.rerr}, 32'h0000_0001);
    $display("clock and interrupt tests done");
    for (int w = 0; w < 4; w++) begin
      host.cfg(16'h0010 | 16'(w << 8));
      host.sample(24'h87_6543);
      @(negedge clk);
      cmp(dataWord, expWord[w]);
      cmp(32'(dataWordValid), 32'h0000_0001);
      @(posedge clk);
    end
    host.conversionAvail <= 1'b1;
    repeat (3) @(posedge clk);
    outs(16'h0310, c, 3'b010);
    host.cfg(16'h0312);
    host.conversionAvail <= 1'b0;
    repeat (3) @(posedge clk);
    outs(16'h0312, c, 3'b100);
    reset_n <= 1'b0;
    @(posedge clk);
    outs(16'h0510, 16'h0F8E, 3'b110);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(IRQ_STATUS_ADDR, 32'h0000_0000);
    rd(MODE_ADDR, 32'h0000_0510);
    $display("word, pin and reset tests done");
    stop_test();
  end
endmodule : tb
